// ==== pkg/swma_map.vh ====
// offsets, fields and reset values of the watermark admission block
`ifndef SWMA_MAP_VH
`define SWMA_MAP_VH
// apb register byte offsets
`define SWMA_OFF_CTRL 8'h00
`define SWMA_OFF_INDEX 8'h04
`define SWMA_OFF_TX_PRIV 8'h08
`define SWMA_OFF_TX_HOG 8'h0C
`define SWMA_OFF_ALERT 8'h10
`define SWMA_OFF_SAMPLE 8'h14
`define SWMA_OFF_SCMD 8'h18
`define SWMA_OFF_SOFT 8'h1C
`define SWMA_OFF_PHOG 8'h20
`define SWMA_OFF_ABOVE 8'h24
`define SWMA_OFF_BELOW 8'h28
`define SWMA_OFF_CNT_LO 8'h2C
`define SWMA_OFF_CNT_HI 8'h30
`define SWMA_OFF_STATUS 8'h34
// ctrl fields
`define SWMA_CTRL_PRIV_EN 0
`define SWMA_CTRL_PART_EN 1
`define SWMA_CTRL_OVL_LSB 8
`define SWMA_CTRL_MSEL_LSB 12
`define SWMA_CTRL_RESET 32'h00000000
// soft-drop word fields
`define SWMA_SOFT_JIT_LSB 16
// sizes
`define SWMA_NPORT 80
`define SWMA_NPHYS 76
`define SWMA_LAST_PORT 7'h4F
`define SWMA_NTXMP 12
`define SWMA_TBL_DEPTH 1280
`define SWMA_LFSR_SEED 16'hACE1
`define SWMA_LFSR_TAPS 16'hB400
`endif

// ==== sim/swma_admission_checker.sv ====
// assertions on the frame answer of the watermark admission block
`timescale 1ns/100ps
module swma_admission_checker (
  // clock and reset
  input wire clk,
  input wire resetn,
  // frame request
  input wire frame_valid,
  input wire frame_ready,
  input wire [75:0] dest_mask_in,
  input wire [3:0] ingress_mirror_cmd,
  input wire [3:0] egress_mirror_cmd,
  // receive usage and limits
  input wire [15:0] rx_port_seg,
  input wire [15:0] rx_port_frm,
  input wire [15:0] rx_priv_seg_lim,
  input wire [15:0] rx_priv_frm_lim,
  input wire [15:0] rx_hog_seg_lim,
  input wire [15:0] rx_hog_frm_lim,
  input wire [15:0] shared_seg,
  input wire [15:0] shared_frm,
  input wire [15:0] shared_seg_lim,
  input wire [15:0] shared_frm_lim,
  input wire [15:0] global_seg,
  input wire [15:0] global_frm,
  input wire [15:0] global_seg_lim,
  input wire [15:0] global_frm_lim,
  input wire [15:0] free_segments,
  // frame answer
  input wire [6:0] usage_port,
  input wire frame_done,
  input wire frame_drop,
  input wire [79:0] final_dest_mask,
  input wire [3:0] ingress_mirror_out,
  input wire [3:0] egress_mirror_out,
  input wire segments_exhausted
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // receive drop worked out from the live inputs
  wire over_priv = rx_port_seg >= rx_priv_seg_lim || rx_port_frm >= rx_priv_frm_lim;
  wire over_hog = rx_port_seg >= rx_hog_seg_lim || rx_port_frm >= rx_hog_frm_lim;
  wire over_sh = shared_seg >= shared_seg_lim || shared_frm >= shared_frm_lim;
  wire over_gl = global_seg >= global_seg_lim || global_frm >= global_frm_lim;
  wire rx_drop = over_hog || (over_priv && over_sh) || over_gl || free_segments == 16'h0000;
  reg [75:0] cap_mask;
  reg [3:0] cap_ing;
  reg [3:0] cap_eg;
  reg cap_priv;
  reg cap_drop;
  // request kept until its answer; the answer edge still sees the old copy
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cap_mask <= 76'h0;
      cap_ing <= 4'h0;
      cap_eg <= 4'h0;
      cap_priv <= 1'b0;
      cap_drop <= 1'b0;
    end else if (frame_valid && frame_ready) begin
      cap_mask <= dest_mask_in;
      cap_ing <= ingress_mirror_cmd;
      cap_eg <= egress_mirror_cmd;
      cap_priv <= over_priv;
      cap_drop <= rx_drop;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  sequence s_fast_take;
    frame_valid && frame_ready && rx_drop;
  endsequence
  sequence s_slow_take;
    frame_valid && frame_ready && !rx_drop;
  endsequence
  // 80 scan cycles, then the answer
  sequence s_scan;
    ##1 (!frame_ready) [*8] ##72 !frame_done ##1 frame_done;
  endsequence
  a_exhaust_flag: assert property (segments_exhausted == (free_segments == 16'h0000))
    else $error("exhausted flag disagrees with free count");
  a_rx_fast: assert property (s_fast_take |-> ##1 frame_done && frame_drop && final_dest_mask == 80'h0)
    else $error("receive drop not answered next cycle");
  a_scan_len: assert property (s_slow_take |-> s_scan)
    else $error("scan did not end after 81 cycles");
  a_scan_ports: assert property (s_slow_take |=> usage_port == 7'h00 ##79 usage_port == 7'h4F)
    else $error("scan does not walk ports 0 to 79");
  a_mask_subset: assert property (frame_done |-> (final_dest_mask[75:0] & ~cap_mask) == 76'h0)
    else $error("final mask adds a destination");
  a_keep_private: assert property (frame_done && !cap_priv && !cap_drop |-> final_dest_mask[75:0] == cap_mask)
    else $error("destination dropped below receive private level");
  a_zero_drop: assert property (frame_done && final_dest_mask == 80'h0 |-> frame_drop)
    else $error("empty mask not dropped");
  a_drop_empty: assert property (frame_done && frame_drop |-> final_dest_mask == 80'h0)
    else $error("dropped frame keeps destinations");
  a_mirror_trim: assert property (frame_done |-> (egress_mirror_out & ~cap_eg) == 4'h0 &&
    (frame_drop || ingress_mirror_out == cap_ing))
    else $error("mirror commands not trimmed correctly");
endmodule // swma_admission_checker

bind swma_admission swma_admission_checker u_chk (.clk(clk), .resetn(resetn), .frame_valid(frame_valid),
  .frame_ready(frame_ready), .dest_mask_in(dest_mask_in), .ingress_mirror_cmd(ingress_mirror_cmd),
  .egress_mirror_cmd(egress_mirror_cmd), .rx_port_seg(rx_port_seg), .rx_port_frm(rx_port_frm),
  .rx_priv_seg_lim(rx_priv_seg_lim), .rx_priv_frm_lim(rx_priv_frm_lim), .rx_hog_seg_lim(rx_hog_seg_lim),
  .rx_hog_frm_lim(rx_hog_frm_lim), .shared_seg(shared_seg), .shared_frm(shared_frm),
  .shared_seg_lim(shared_seg_lim), .shared_frm_lim(shared_frm_lim), .global_seg(global_seg),
  .global_frm(global_frm), .global_seg_lim(global_seg_lim), .global_frm_lim(global_frm_lim),
  .free_segments(free_segments), .usage_port(usage_port), .frame_done(frame_done), .frame_drop(frame_drop),
  .final_dest_mask(final_dest_mask), .ingress_mirror_out(ingress_mirror_out),
  .egress_mirror_out(egress_mirror_out), .segments_exhausted(segments_exhausted));

// ==== sim/swma_usage_model.sv ====
// transmit queue usage lookup standing in for the queue usage counters
`timescale 1ns/100ps
module swma_usage_model (
  // lookup address from the block
  input wire [6:0] usage_port,
  input wire [3:0] usage_queue,
  // usage answer
  output wire [15:0] tx_queue_usage
);
  // four segments per port number, answered in the same cycle;
  // a wrong queue index lands far above any hog level, so it shows as drops
  assign tx_queue_usage = {usage_queue, 3'b000, usage_port, 2'b00};
endmodule // swma_usage_model

// ==== sim/testbench.sv ====
// self-checking bench for the watermark admission block
`timescale 1ns/100ps
`include "swma_map.vh"
module testbench;
  localparam integer PRIV = 100;
  localparam integer HOG = 200;
  localparam [15:0] LIMS = 16'h333C;
  reg clk = 1'b0;
  reg resetn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0;
  reg frame_valid = 1'b0;
  reg [75:0] dest_mask_in = 76'h0;
  reg [3:0] ing = 4'h0;
  reg [3:0] eg = 4'h0;
  reg [15:0] rx [0:15];
  wire pready, pslverr, frame_ready, frame_done, frame_drop;
  wire [31:0] prdata;
  wire [6:0] usage_port;
  wire [3:0] usage_queue, ing_out, eg_out;
  wire [15:0] tx_queue_usage;
  wire [79:0] final_dest_mask;
  wire sample_fire;
  wire [7:0] sample_cmd_out;
  integer error_cnt = 0;
  integer checks = 0;
  integer seed = 95;
  integer mode, i, k, cnt60, soft_kept, soft_drop;
  integer fires = 0, nfire = 0, ab60 = 0;
  reg [31:0] rd;
  reg err;
  reg [95:0] r96;
  always #10 clk = ~clk;
  // sample pulses counted mid-cycle, away from the edge that launches them
  always @(negedge clk) if (sample_fire === 1'b1) fires = fires + 1;
  // one priority and one partition, so the maps trivially agree
  swma_admission dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .frame_valid(frame_valid),
    .frame_ready(frame_ready), .dest_mask_in(dest_mask_in), .isl_pri(4'h0), .tx_memory_partition(4'h0),
    .ingress_mirror_cmd(ing), .egress_mirror_cmd(eg), .rx_port_seg(rx[0]), .rx_port_frm(rx[1]),
    .rx_priv_seg_lim(rx[2]), .rx_priv_frm_lim(rx[3]), .rx_hog_seg_lim(rx[4]), .rx_hog_frm_lim(rx[5]),
    .shared_seg(rx[6]), .shared_frm(rx[7]), .shared_seg_lim(rx[8]), .shared_frm_lim(rx[9]),
    .global_seg(rx[10]), .global_frm(rx[11]), .global_seg_lim(rx[12]), .global_frm_lim(rx[13]),
    .free_segments(rx[14]), .rx_partition_usage(rx[15]), .usage_port(usage_port), .usage_queue(usage_queue),
    .tx_queue_usage(tx_queue_usage), .frame_done(frame_done), .frame_drop(frame_drop),
    .final_dest_mask(final_dest_mask), .ingress_mirror_out(ing_out), .egress_mirror_out(eg_out),
    .sample_fire(sample_fire), .sample_cmd_out(sample_cmd_out), .segments_exhausted());
  swma_usage_model usage_model (.usage_port(usage_port), .usage_queue(usage_queue),
    .tx_queue_usage(tx_queue_usage));
  ////////////////////////////////////////////////////////////////////////
  task chk(input [79:0] got, input [79:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("BAD at %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // one apb transfer, held until pready is seen high
  task apb(input w, input [7:0] a, input [31:0] d);
    integer n;
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      @(posedge clk);
      while (pready !== 1'b1 && n < 20) begin
        @(posedge clk);
        n = n + 1;
      end
      if (n >= 20) error_cnt = error_cnt + 1;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
    end
  endtask
  // receive inputs: 0 under private, 1 over private, 2 hog, 3 private and shared, 4 global, 5 no segments
  function [15:0] rx_val(input integer j, input integer kind);
    begin
      rx_val = LIMS[j] ? 16'h8000 : 16'h0000;
      if (j == 14) rx_val = 16'h0100;
      if (j == 2 && (kind == 1 || kind == 3)) rx_val = 16'h0000;
      if ((j == 1 && kind == 2) || (j == 6 && (kind == 3 || kind == 6)) || (j == 11 && kind == 4)) rx_val = 16'h8000;
      if (j == 14 && kind == 5) rx_val = 16'h0000;
    end
  endfunction
  // one frame against the model: overlay on for all mirrors, usage four per port
  task frame(input [75:0] m, input [3:0] mi, input [3:0] me, input integer kind);
    reg [79:0] m1, drp, care;
    reg rxd;
    integer j, n, u;
    begin
      for (j = 0; j < 16; j = j + 1) rx[j] <= rx_val(j, kind);
      dest_mask_in <= m;
      ing <= mi;
      eg <= me;
      frame_valid <= 1'b1;
      m1 = {mi | me, m};
      rxd = kind >= 2 && kind <= 5;
      drp = 80'h0;
      care = {80{1'b1}};
      for (j = 0; j < 80; j = j + 1) begin
        u = 4 * j;
        if (m1[j] && kind == 1 && (u >= HOG || (u >= PRIV && mode >= 2))) drp[j] = 1'b1;
        if (kind == 1 && u >= PRIV && u < HOG && mode == 1) care[j] = 1'b0;
        if (!rxd && m1[j] && !drp[j] && u >= 240) nfire = nfire + 1;
      end
      if (drp[60]) cnt60 = cnt60 + 1;
      if (!rxd && m1[60]) ab60 = 1;
      @(posedge clk);
      frame_valid <= 1'b0;
      n = 0;
      @(negedge clk);
      while (frame_done !== 1'b1 && n < 200) begin
        @(negedge clk);
        n = n + 1;
      end
      chk(80'(frame_done), 80'h1);
      chk(final_dest_mask & care, (rxd ? 80'h0 : m1 & ~drp) & care);
      chk(80'(frame_drop), 80'(rxd || (m1 & ~drp) == 80'h0));
      chk(80'(eg_out), 80'(rxd ? 4'h0 : me & ~drp[79:76]));
      for (j = 0; j < 80; j = j + 1) begin
        if (!care[j] && m1[j] && final_dest_mask[j]) soft_kept = soft_kept + 1;
        if (!care[j] && m1[j] && !final_dest_mask[j]) soft_drop = soft_drop + 1;
      end
      @(posedge clk);
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    for (i = 0; i < 16; i = i + 1) rx[i] = 16'h0000;
    cnt60 = 0;
    soft_kept = 0;
    soft_drop = 0;
    mode = 0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    apb(1'b0, `SWMA_OFF_CTRL, 32'h0);
    chk(80'(rd), 80'(`SWMA_CTRL_RESET));
    apb(1'b0, 8'hFC, 32'h0);
    chk(80'({err, rd}), 80'h1_0000_0000);
    $display("test registers done");
    // tables are not reset, so all of them go in before traffic
    for (i = 0; i < 80; i = i + 1) begin
      apb(1'b1, `SWMA_OFF_INDEX, i << 4);
      apb(1'b1, `SWMA_OFF_TX_PRIV, PRIV);
      apb(1'b1, `SWMA_OFF_TX_HOG, HOG);
      apb(1'b1, `SWMA_OFF_ALERT, 32'h00C8_0064);
      apb(1'b1, `SWMA_OFF_SAMPLE, 32'h0000_00F0);
    end
    apb(1'b1, `SWMA_OFF_INDEX, 32'h0);
    apb(1'b1, `SWMA_OFF_SOFT, 32'h0);
    apb(1'b1, `SWMA_OFF_PHOG, 32'h0);
    apb(1'b1, `SWMA_OFF_SCMD, 32'h0000_005A);
    for (mode = 0; mode < 4; mode = mode + 1) begin
      apb(1'b1, `SWMA_OFF_CTRL, 32'h0F00 | mode);
      for (k = 0; k < 12; k = k + 1) begin
        r96 = {$random(seed), $random(seed), $random(seed)};
        frame(r96[75:0], r96[79:76], r96[83:80], k < 7 ? k : 1);
      end
      $display("test mode %0d done", mode);
    end
    frame(76'h0, 4'h0, 4'h0, 1);
    apb(1'b1, `SWMA_OFF_INDEX, 32'h3C0);
    apb(1'b0, `SWMA_OFF_CNT_LO, 32'h0);
    chk(80'(rd), 80'(cnt60));
    apb(1'b0, `SWMA_OFF_CNT_HI, 32'h0);
    chk(80'(rd), 80'h0);
    apb(1'b0, `SWMA_OFF_ABOVE, 32'h0);
    chk(80'(rd), 80'(ab60));
    apb(1'b1, `SWMA_OFF_ABOVE, 32'h1);
    apb(1'b0, `SWMA_OFF_ABOVE, 32'h0);
    chk(80'(rd), 80'h0);
    chk(80'(fires), 80'(nfire));
    chk(80'(sample_cmd_out), 80'h5A);
    chk(80'(soft_kept > 0 && soft_drop > 0), 80'h1);
    $display("test counters done");
    tally_and_finish;
  end
  // watchdog, well beyond the expected run
  initial begin
    #(20 * 30000);
    error_cnt = error_cnt + 1;
    $display("watchdog expired");
    tally_and_finish;
  end
endmodule // testbench

// ==== src/swma_admission.v ====
// frame admission by receive and transmit memory watermarks
`timescale 1ns/100ps
`include "swma_map.vh"
module swma_admission (
  // clock and reset
  input wire clk,
  input wire resetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // frame request
  input wire frame_valid,
  output wire frame_ready,
  input wire [75:0] dest_mask_in,
  input wire [3:0] isl_pri,
  input wire [3:0] tx_memory_partition,
  input wire [3:0] ingress_mirror_cmd,
  input wire [3:0] egress_mirror_cmd,
  // receive usage and limits
  input wire [15:0] rx_port_seg,
  input wire [15:0] rx_port_frm,
  input wire [15:0] rx_priv_seg_lim,
  input wire [15:0] rx_priv_frm_lim,
  input wire [15:0] rx_hog_seg_lim,
  input wire [15:0] rx_hog_frm_lim,
  input wire [15:0] shared_seg,
  input wire [15:0] shared_frm,
  input wire [15:0] shared_seg_lim,
  input wire [15:0] shared_frm_lim,
  input wire [15:0] global_seg,
  input wire [15:0] global_frm,
  input wire [15:0] global_seg_lim,
  input wire [15:0] global_frm_lim,
  input wire [15:0] free_segments,
  input wire [15:0] rx_partition_usage,
  // transmit queue usage lookup
  output wire [6:0] usage_port,
  output wire [3:0] usage_queue,
  input wire [15:0] tx_queue_usage,
  // frame answer
  output reg frame_done,
  output reg frame_drop,
  output reg [79:0] final_dest_mask,
  output reg [3:0] ingress_mirror_out,
  output reg [3:0] egress_mirror_out,
  output reg sample_fire,
  output reg [7:0] sample_cmd_out,
  output wire segments_exhausted
);

  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_SCAN = 2'b10;

  reg [1:0] state_reg;
  reg [6:0] port_reg;
  reg [79:0] mask_reg;
  reg [79:0] drop_reg;
  reg [3:0] pri_reg;
  reg [3:0] tx_memory_partition_reg;
  reg [3:0] imir_reg;
  reg [3:0] emir_reg;
  reg priv_hit_reg;
  reg part_act_reg;
  reg signed [17:0] free_reg;
  reg [31:0] ctrl_reg;
  reg [10:0] index_reg;
  // watermark tables, no reset: software loads them before traffic
  reg [15:0] priv_mem [0:`SWMA_TBL_DEPTH-1];
  reg [15:0] hog_mem [0:`SWMA_TBL_DEPTH-1];
  reg [31:0] alert_mem [0:`SWMA_TBL_DEPTH-1];
  reg [15:0] sample_mem [0:`SWMA_TBL_DEPTH-1];
  reg [7:0] scmd_mem [0:15];
  reg [18:0] soft_mem [0:15];
  reg [15:0] phog_mem [0:15];
  wire [15:0] rnd;
  wire [959:0] above_bus;
  wire [959:0] below_bus;
  wire [5119:0] cnt_bus;

  swma_lfsr u_lfsr (
    .clk(clk),
    .resetn(resetn),
    .rnd(rnd)
  );

  ////////////////////////////////////////////////////////////////////////
  // apb decode: zero wait states, prdata captured in the setup cycle
  wire apb_wr = psel & penable & pwrite;
  wire apb_setup = psel & ~penable;
  reg addr_ok;
  always @* begin
    case (paddr)
      `SWMA_OFF_CTRL, `SWMA_OFF_INDEX, `SWMA_OFF_TX_PRIV, `SWMA_OFF_TX_HOG,
      `SWMA_OFF_ALERT, `SWMA_OFF_SAMPLE, `SWMA_OFF_SCMD, `SWMA_OFF_SOFT,
      `SWMA_OFF_PHOG, `SWMA_OFF_ABOVE, `SWMA_OFF_BELOW, `SWMA_OFF_CNT_LO,
      `SWMA_OFF_CNT_HI, `SWMA_OFF_STATUS: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;

  ////////////////////////////////////////////////////////////////////////
  // receive side verdict on the arriving frame
  assign segments_exhausted = (free_segments == 16'h0000);
  wire rx_private_limit_reached = (rx_port_seg >= rx_priv_seg_lim) | (rx_port_frm >= rx_priv_frm_lim);
  wire rx_port_hog_reached = (rx_port_seg >= rx_hog_seg_lim) | (rx_port_frm >= rx_hog_frm_lim);
  wire rx_shared_limit_reached = (shared_seg >= shared_seg_lim) | (shared_frm >= shared_frm_lim);
  wire global_limit_reached = (global_seg >= global_seg_lim) | (global_frm >= global_frm_lim);
  wire rx_drop = rx_port_hog_reached | (rx_private_limit_reached & rx_shared_limit_reached) |
                 global_limit_reached | segments_exhausted;

  // partition soft-drop guard with random jitter
  wire [18:0] soft_word = soft_mem[isl_pri];
  wire [15:0] soft_drop_level = soft_word[15:0];
  wire [2:0] jitter_width_field = soft_word[`SWMA_SOFT_JIT_LSB+2:`SWMA_SOFT_JIT_LSB];
  wire [7:0] jit_mask = (8'h01 << jitter_width_field) - 8'h01;
  wire [6:0] jitter = rnd[6:0] & jit_mask[6:0];
  wire [16:0] soft_thresh = {1'b0, soft_drop_level} + {10'h000, jitter};
  wire partition_soft_drop_active = ({1'b0, rx_partition_usage} >= soft_thresh);
  wire [15:0] hog_level = phog_mem[isl_pri];
  wire signed [17:0] partition_free_space = $signed({2'b00, hog_level}) - $signed({2'b00, rx_partition_usage});

  // overlay bits of the augmented mask
  wire [3:0] overlay_forward_en = ctrl_reg[`SWMA_CTRL_OVL_LSB+3:`SWMA_CTRL_OVL_LSB];
  wire [3:0] mirror_queue_select = ctrl_reg[`SWMA_CTRL_MSEL_LSB+3:`SWMA_CTRL_MSEL_LSB];
  wire [3:0] ovl_bits = (ingress_mirror_cmd | egress_mirror_cmd) & overlay_forward_en;

  ////////////////////////////////////////////////////////////////////////
  // per-destination evaluation, one port per clock
  wire is_ovl = (port_reg >= 7'd76);
  wire msel = mirror_queue_select[port_reg[1:0]];
  wire [3:0] wm_q = is_ovl ? {3'b000, msel} : pri_reg;
  wire [3:0] use_q = is_ovl ? {3'b000, msel} : tx_memory_partition_reg;
  assign usage_port = port_reg;
  assign usage_queue = use_q;
  wire [10:0] wm_addr = {port_reg, wm_q};
  wire [10:0] use_addr = {port_reg, use_q};
  wire scanning = state_reg[1];
  wire dest_on = mask_reg[port_reg];
  wire over_tx_priv = tx_queue_usage >= priv_mem[wm_addr];
  wire over_tx_hog = tx_queue_usage >= hog_mem[wm_addr];
  wire signed [17:0] use_s = $signed({2'b00, tx_queue_usage});
  wire at_free = use_s >= free_reg;
  wire at_half = use_s >= (free_reg >>> 1);
  wire soft_drop_private_en = ctrl_reg[`SWMA_CTRL_PRIV_EN];
  wire soft_drop_partition_free_en = ctrl_reg[`SWMA_CTRL_PART_EN];

  // drop probability code: 0 none, 1 half, 2 certain
  reg [1:0] prob_part;
  reg [1:0] prob;
  reg per_dest_drop;
  always @* begin
    prob_part = 2'd0;
    if (soft_drop_partition_free_en && part_act_reg) begin
      if (at_free) begin
        prob_part = 2'd2;
      end else if (at_half) begin
        prob_part = 2'd1;
      end
    end
    prob = prob_part;
    if (soft_drop_private_en && prob_part == 2'd0) begin
      prob = 2'd1;
    end
    per_dest_drop = 1'b0;
    if (dest_on && priv_hit_reg) begin
      if (over_tx_hog) begin
        per_dest_drop = 1'b1;
      end else if (over_tx_priv) begin
        per_dest_drop = (prob == 2'd2) | ((prob == 2'd1) & rnd[15]);
      end
      // below private the destination stays
    end
  end

  wire [79:0] drop_now = drop_reg | ({79'h0, per_dest_drop} << port_reg);
  wire [79:0] final_mask = mask_reg & ~drop_now;
  wire last_port = (port_reg == `SWMA_LAST_PORT);
  wire [31:0] alert_lv = alert_mem[use_addr];
  wire alert_eval = scanning & dest_on;
  wire [11:0] q_bit = 12'h001 << use_q;

  ////////////////////////////////////////////////////////////////////////
  // frame sequencer: one decision per accepted frame
  assign frame_ready = state_reg[0];
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
      port_reg <= 7'h00;
      mask_reg <= 80'h0;
      drop_reg <= 80'h0;
      pri_reg <= 4'h0;
      tx_memory_partition_reg <= 4'h0;
      imir_reg <= 4'h0;
      emir_reg <= 4'h0;
      priv_hit_reg <= 1'b0;
      part_act_reg <= 1'b0;
      free_reg <= 18'sd0;
      frame_done <= 1'b0;
      frame_drop <= 1'b0;
      final_dest_mask <= 80'h0;
      ingress_mirror_out <= 4'h0;
      egress_mirror_out <= 4'h0;
    end else begin
      frame_done <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (frame_valid) begin
            mask_reg <= {ovl_bits, dest_mask_in};
            drop_reg <= 80'h0;
            pri_reg <= isl_pri;
            tx_memory_partition_reg <= tx_memory_partition;
            imir_reg <= ingress_mirror_cmd;
            emir_reg <= egress_mirror_cmd;
            priv_hit_reg <= rx_private_limit_reached;
            part_act_reg <= partition_soft_drop_active;
            free_reg <= partition_free_space;
            port_reg <= 7'h00;
            if (rx_drop) begin
              // receive drop ends the frame at once, no mask survives
              frame_done <= 1'b1;
              frame_drop <= 1'b1;
              final_dest_mask <= 80'h0;
              ingress_mirror_out <= 4'h0;
              egress_mirror_out <= 4'h0;
            end else begin
              state_reg <= ST_SCAN;
            end
          end
        end
        ST_SCAN: begin
          drop_reg <= drop_now;
          port_reg <= last_port ? 7'h00 : port_reg + 7'h01;
          if (last_port) begin
            state_reg <= ST_IDLE;
            frame_done <= 1'b1;
            final_dest_mask <= final_mask;
            frame_drop <= (final_mask == 80'h0);
            ingress_mirror_out <= imir_reg;
            egress_mirror_out <= emir_reg & ~(mask_reg[79:76] & drop_now[79:76]);
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sampling trigger on kept destinations at or above their sample level
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sample_fire <= 1'b0;
      sample_cmd_out <= 8'h00;
    end else begin
      sample_fire <= 1'b0;
      if (alert_eval && !per_dest_drop && sample_mem[use_addr] != 16'h0000 &&
          tx_queue_usage >= sample_mem[use_addr]) begin
        sample_fire <= 1'b1;
        sample_cmd_out <= scmd_mem[use_q];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-port alert status and drop counters; hardware set beats clear
  genvar g;
  generate
    for (g = 0; g < `SWMA_NPORT; g = g + 1) begin : g_port
      reg [11:0] above_reg;
      reg [11:0] below_reg;
      reg [63:0] cnt_reg;
      wire hit = scanning & (port_reg == g);
      wire sel = (index_reg[10:4] == g);
      wire [11:0] clr_a = (apb_wr && paddr == `SWMA_OFF_ABOVE && sel) ? pwdata[11:0] : 12'h000;
      wire [11:0] clr_b = (apb_wr && paddr == `SWMA_OFF_BELOW && sel) ? pwdata[11:0] : 12'h000;
      wire [11:0] set_a = (hit && dest_on && tx_queue_usage >= alert_lv[31:16]) ? q_bit : 12'h000;
      wire [11:0] set_b = (hit && dest_on && tx_queue_usage < alert_lv[15:0]) ? q_bit : 12'h000;
      always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          above_reg <= 12'h000;
          below_reg <= 12'h000;
          cnt_reg <= 64'h0;
        end else begin
          above_reg <= (above_reg & ~clr_a) | set_a;
          below_reg <= (below_reg & ~clr_b) | set_b;
          if (hit && per_dest_drop) begin
            cnt_reg <= cnt_reg + 64'h1;
          end
        end
      end
      assign above_bus[g*12 +: 12] = above_reg;
      assign below_bus[g*12 +: 12] = below_reg;
      assign cnt_bus[g*64 +: 64] = cnt_reg;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // register writes; watermarks may change during traffic
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg <= `SWMA_CTRL_RESET;
      index_reg <= 11'h000;
    end else if (apb_wr) begin
      if (paddr == `SWMA_OFF_CTRL) begin
        ctrl_reg <= pwdata & 32'h0000FF03;
      end
      if (paddr == `SWMA_OFF_INDEX) begin
        index_reg <= pwdata[10:0];
      end
    end
  end

  // table writes through the index window
  always @(posedge clk) begin
    if (apb_wr) begin
      case (paddr)
        `SWMA_OFF_TX_PRIV: priv_mem[index_reg] <= pwdata[15:0];
        `SWMA_OFF_TX_HOG: hog_mem[index_reg] <= pwdata[15:0];
        `SWMA_OFF_ALERT: alert_mem[index_reg] <= pwdata;
        `SWMA_OFF_SAMPLE: sample_mem[index_reg] <= pwdata[15:0];
        `SWMA_OFF_SCMD: scmd_mem[index_reg[3:0]] <= pwdata[7:0];
        `SWMA_OFF_SOFT: soft_mem[index_reg[3:0]] <= pwdata[18:0];
        `SWMA_OFF_PHOG: phog_mem[index_reg[3:0]] <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux, captured in setup so prdata is a flop
  wire [6:0] rport = index_reg[10:4];
  reg [31:0] rd;
  always @* begin
    case (paddr)
      `SWMA_OFF_CTRL: rd = ctrl_reg;
      `SWMA_OFF_INDEX: rd = {21'h0, index_reg};
      `SWMA_OFF_TX_PRIV: rd = {16'h0, priv_mem[index_reg]};
      `SWMA_OFF_TX_HOG: rd = {16'h0, hog_mem[index_reg]};
      `SWMA_OFF_ALERT: rd = alert_mem[index_reg];
      `SWMA_OFF_SAMPLE: rd = {16'h0, sample_mem[index_reg]};
      `SWMA_OFF_SCMD: rd = {24'h0, scmd_mem[index_reg[3:0]]};
      `SWMA_OFF_SOFT: rd = {13'h0, soft_mem[index_reg[3:0]]};
      `SWMA_OFF_PHOG: rd = {16'h0, phog_mem[index_reg[3:0]]};
      `SWMA_OFF_ABOVE: rd = {20'h0, above_bus[rport*12 +: 12]};
      `SWMA_OFF_BELOW: rd = {20'h0, below_bus[rport*12 +: 12]};
      `SWMA_OFF_CNT_LO: rd = cnt_bus[rport*64 +: 32];
      `SWMA_OFF_CNT_HI: rd = cnt_bus[rport*64+32 +: 32];
      `SWMA_OFF_STATUS: rd = {30'h0, segments_exhausted, scanning};
      default: rd = 32'h0;
    endcase
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h0;
    end else if (apb_setup) begin
      prdata <= rd;
    end
  end

endmodule // swma_admission

// ==== src/swma_lfsr.v ====
// free-running pseudo-random source for jitter and soft dropping
`timescale 1ns/100ps
`include "swma_map.vh"
module swma_lfsr (
  // clock and reset
  input wire clk,
  input wire resetn,
  // random word
  output wire [15:0] rnd
);

  reg [15:0] lfsr_reg;

  ////////////////////////////////////////////////////////////////////////
  // galois shift, advanced every clock so each draw is fresh
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lfsr_reg <= `SWMA_LFSR_SEED;
    end else begin
      lfsr_reg <= {1'b0, lfsr_reg[15:1]} ^ (lfsr_reg[0] ? `SWMA_LFSR_TAPS : 16'h0000);
    end
  end

  assign rnd = lfsr_reg;

endmodule // swma_lfsr
